// ---- hdl/dbgev_regs.vh ----
// Behaviour
// - Four breakpoint hit flags, one for each breakpoint address register.
// - On any enabled match, set every currently matching hit flag, enabled or not.
// - Hardware only sets status flags; software alone clears them.
// - An enabled breakpoint match (global or local) raises the debug exception.
// - Instruction breakpoints are faults before execution; data breakpoints are traps after.
// - Debug register access under global detect protect raises exception, sets guarded flag.
// - Entering the handler for a guarded access clears global detect protect.
// - An exception from the step trap flag sets the single step flag.
// - Task switch into a trapping task sets task switch flag, traps before first instruction.
// - The resume flag suppresses an instruction breakpoint at the resume address.
// - Usage field 00 execute, 01 data write, 11 data read or write; 10 undefined.
// - Length field gives aligned 1, 2 or 4 byte region; partial overlap matches.
`ifndef DBGEV_REGS_VH
`define DBGEV_REGS_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define DBGEV_OFS_BP_ADDR0 5'h00
`define DBGEV_OFS_BP_ADDR1 5'h04
`define DBGEV_OFS_BP_ADDR2 5'h08
`define DBGEV_OFS_BP_ADDR3 5'h0c
`define DBGEV_OFS_CTRL 5'h10
`define DBGEV_OFS_STATUS 5'h14
`define DBGEV_OFS_MASK 5'h18

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define DBGEV_CTRL_LOCAL_EN(i) (2*(i))
`define DBGEV_CTRL_GLOBAL_EN(i) (2*(i)+1)
`define DBGEV_CTRL_GD 13
`define DBGEV_CTRL_USAGE(i) (16+4*(i))
`define DBGEV_CTRL_LEN(i) (18+4*(i))
`define DBGEV_CTRL_WMASK 32'hffff20ff

// ---------------------------------------------------------------
// Status and mask fields
// ---------------------------------------------------------------
`define DBGEV_ST_GUARDED 13
`define DBGEV_ST_STEP 14
`define DBGEV_ST_TASK 15
`define DBGEV_ST_VALID 32'h0000e00f

// ---------------------------------------------------------------
// Encodings and reset values
// ---------------------------------------------------------------
`define DBGEV_USE_EXEC 2'h0
`define DBGEV_USE_WRITE 2'h1
`define DBGEV_USE_RDWR 2'h3
`define DBGEV_LEN_1 2'h0
`define DBGEV_LEN_2 2'h1
`define DBGEV_LEN_4 2'h3
`define DBGEV_RST_WORD 32'h00000000
`define DBGEV_RESP_OKAY 2'h0
`define DBGEV_RESP_SLVERR 2'h2

`endif

// ---- hdl/dbgev_bp_match.v ----
`timescale 1ns/1ps
`default_nettype none
`include "dbgev_regs.vh"

module dbgev_bp_match #(
   parameter NUM_BP = 4
) (
   // Breakpoint setup.
   input wire [32*NUM_BP-1:0] i_bp_addr,
   input wire [2*NUM_BP-1:0] i_usage,
   input wire [2*NUM_BP-1:0] i_len,
   // Instruction start address.
   input wire [31:0] i_ins_addr,
   // Data access, dword address and byte lanes.
   input wire [29:0] i_dat_dword,
   input wire [3:0] i_dat_be,
   input wire i_dat_wr,
   // Per-breakpoint matches.
   output wire [NUM_BP-1:0] o_ins_hit,
   output wire [NUM_BP-1:0] o_dat_hit
);

   // Byte lanes covered by an aligned breakpoint region.
   function [3:0] region_lanes;
      input [1:0] len;
      input [1:0] lo;
      begin
         case (len)
            `DBGEV_LEN_2: region_lanes = lo[1] ? 4'hc : 4'h3;
            `DBGEV_LEN_4: region_lanes = 4'hf;
            default: region_lanes = 4'h1 << lo;
         endcase
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < NUM_BP; g = g + 1) begin : g_bp
         wire [31:0] a = i_bp_addr[32*g +: 32];
         wire [1:0] use_f = i_usage[2*g +: 2];
         wire [3:0] lanes = region_lanes(i_len[2*g +: 2], a[1:0]);
         wire [3:0] ilane = 4'h1 << i_ins_addr[1:0];
         // Execution match: instruction start inside region.
         assign o_ins_hit[g] = (use_f == `DBGEV_USE_EXEC) && (a[31:2] == i_ins_addr[31:2]) &&
            |(lanes & ilane);
         // Data match: any touched lane overlaps region.
         assign o_dat_hit[g] = (a[31:2] == i_dat_dword) && |(lanes & i_dat_be) &&
            ((use_f == `DBGEV_USE_RDWR) || (use_f == `DBGEV_USE_WRITE && i_dat_wr));
      end
   endgenerate

endmodule // dbgev_bp_match
`default_nettype wire

// ---- hdl/dbgev_irq.v ----
`timescale 1ns/1ps
`default_nettype none
`include "dbgev_regs.vh"

module dbgev_irq (
   // Clock and control.
   input wire i_clk,
   input wire i_reset,
   input wire i_ce,
   // Status set and write-one-to-clear.
   input wire [31:0] i_set,
   input wire [31:0] i_clr,
   // Mask write.
   input wire i_mask_we,
   input wire [31:0] i_mask_wdata,
   // State.
   output reg [31:0] o_status,
   output reg [31:0] o_mask,
   output wire o_irq
);

   // Sticky status; a set in the same cycle as a clear wins.
   always @(posedge i_clk) begin
      if (i_reset) begin
         o_status <= `DBGEV_RST_WORD;
         o_mask <= `DBGEV_RST_WORD;
      end else if (i_ce) begin
         o_status <= ((o_status & ~i_clr) | i_set) & `DBGEV_ST_VALID;
         if (i_mask_we) begin
            o_mask <= i_mask_wdata & `DBGEV_ST_VALID;
         end
      end
   end

   // Level interrupt while any unmasked flag is set.
   assign o_irq = |(o_status & o_mask);

endmodule // dbgev_irq
`default_nettype wire

// ---- hdl/dbgev_top.v ----
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dbgev_regs.vh"

module dbgev_top #(
   parameter NUM_BP = 4
) (
   // Clock, reset, enable.
   input wire i_clk,
   input wire i_reset,
   input wire i_ce,
   // AXI4-Lite write address.
   input wire i_awvalid,
   output wire o_awready,
   input wire [4:0] i_awaddr,
   // AXI4-Lite write data.
   input wire i_wvalid,
   output wire o_wready,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   // AXI4-Lite write response.
   output reg o_bvalid,
   input wire i_bready,
   output reg [1:0] o_bresp,
   // AXI4-Lite read address.
   input wire i_arvalid,
   output wire o_arready,
   input wire [4:0] i_araddr,
   // AXI4-Lite read data.
   output reg o_rvalid,
   input wire i_rready,
   output reg [31:0] o_rdata,
   output reg [1:0] o_rresp,
   // Instruction about to execute.
   input wire i_ins_start,
   input wire [31:0] i_ins_addr,
   input wire i_resume_flag,
   input wire i_dreg_access,
   // Data transfer completed.
   input wire i_dat_valid,
   input wire [29:0] i_dat_dword,
   input wire [3:0] i_dat_be,
   input wire i_dat_wr,
   // Instruction retired.
   input wire i_ins_done,
   input wire i_step_trap_flag,
   input wire i_task_switch,
   input wire i_tss_trap_bit,
   // Exception request to the core.
   output reg o_dbg_exc,
   output reg o_exc_fault,
   output wire o_global_detect_protect,
   output wire o_irq
);

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   reg [31:0] bp_addr_r [0:NUM_BP-1];
   reg [31:0] ctrl_r;
   reg aw_have_r;
   reg w_have_r;
   reg [4:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   reg [NUM_BP-1:0] pend_hit_r;
   reg pend_en_r;
   wire [31:0] status;
   wire [31:0] mask;

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------

   // Offset decode; bit 3 flags an unmapped offset.
   function [3:0] reg_index;
      input [4:0] ofs;
      begin
         case (ofs)
            `DBGEV_OFS_BP_ADDR0: reg_index = 4'h0;
            `DBGEV_OFS_BP_ADDR1: reg_index = 4'h1;
            `DBGEV_OFS_BP_ADDR2: reg_index = 4'h2;
            `DBGEV_OFS_BP_ADDR3: reg_index = 4'h3;
            `DBGEV_OFS_CTRL: reg_index = 4'h4;
            `DBGEV_OFS_STATUS: reg_index = 4'h5;
            `DBGEV_OFS_MASK: reg_index = 4'h6;
            default: reg_index = 4'h8;
         endcase
      end
   endfunction

   // Merge write data into an old word by byte strobes.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
               merge[8*k +: 8] = data[8*k +: 8];
            end
         end
      end
   endfunction

   // Expand byte strobes to a bit mask.
   function [31:0] strb_bits;
      input [3:0] strb;
      begin
         strb_bits = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      end
   endfunction

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------

   // Address and data are taken independently, one write at a time.
   assign o_awready = !aw_have_r && !o_bvalid;
   assign o_wready = !w_have_r && !o_bvalid;

   wire aw_take = i_awvalid && o_awready;
   wire w_take = i_wvalid && o_wready;
   wire wr_go = aw_have_r && w_have_r && !o_bvalid;
   wire [3:0] wr_idx = reg_index(aw_addr_r);
   wire wr_bad = wr_idx[3];

   // Write strobes into the control, status and mask registers.
   wire ctrl_we = wr_go && (wr_idx == 4'h4);
   wire stat_we = wr_go && (wr_idx == 4'h5);
   wire mask_we = wr_go && (wr_idx == 4'h6);

   // Capture address and data, then answer.
   always @(posedge i_clk) begin
      if (i_reset) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 5'h00;
         w_data_r <= `DBGEV_RST_WORD;
         w_strb_r <= 4'h0;
         o_bvalid <= 1'b0;
         o_bresp <= `DBGEV_RESP_OKAY;
      end else if (i_ce) begin
         if (aw_take) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= i_awaddr;
         end
         if (w_take) begin
            w_have_r <= 1'b1;
            w_data_r <= i_wdata;
            w_strb_r <= i_wstrb;
         end
         if (wr_go) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp <= wr_bad ? `DBGEV_RESP_SLVERR : `DBGEV_RESP_OKAY;
         end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------

   // One read at a time; the address is refused while data waits.
   assign o_arready = !o_rvalid;

   wire ar_take = i_arvalid && o_arready;
   wire [3:0] rd_idx = reg_index(i_araddr);
   reg [31:0] rd_word;

   // Read data multiplexer; unmapped reads return zero.
   always @* begin
      case (rd_idx)
         4'h0: rd_word = bp_addr_r[0];
         4'h1: rd_word = bp_addr_r[1];
         4'h2: rd_word = bp_addr_r[2];
         4'h3: rd_word = bp_addr_r[3];
         4'h4: rd_word = ctrl_r;
         4'h5: rd_word = status;
         4'h6: rd_word = mask;
         default: rd_word = `DBGEV_RST_WORD;
      endcase
   end

   // Register the read answer.
   always @(posedge i_clk) begin
      if (i_reset) begin
         o_rvalid <= 1'b0;
         o_rdata <= `DBGEV_RST_WORD;
         o_rresp <= `DBGEV_RESP_OKAY;
      end else if (i_ce) begin
         if (ar_take) begin
            o_rvalid <= 1'b1;
            o_rdata <= rd_word;
            o_rresp <= rd_idx[3] ? `DBGEV_RESP_SLVERR : `DBGEV_RESP_OKAY;
         end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Breakpoint registers
   // ---------------------------------------------------------------

   // Address registers, written by byte strobes.
   genvar g;
   generate
      for (g = 0; g < NUM_BP; g = g + 1) begin : g_addr
         always @(posedge i_clk) begin
            if (i_reset) begin
               bp_addr_r[g] <= `DBGEV_RST_WORD;
            end else if (i_ce && wr_go && (wr_idx == g)) begin
               bp_addr_r[g] <= merge(bp_addr_r[g], w_data_r, w_strb_r);
            end
         end
      end
   endgenerate

   // Flatten setup for the comparators.
   wire [32*NUM_BP-1:0] addr_flat;
   wire [2*NUM_BP-1:0] usage_flat;
   wire [2*NUM_BP-1:0] len_flat;
   wire [NUM_BP-1:0] bp_en;
   generate
      for (g = 0; g < NUM_BP; g = g + 1) begin : g_flat
         assign addr_flat[32*g +: 32] = bp_addr_r[g];
         assign usage_flat[2*g +: 2] = ctrl_r[`DBGEV_CTRL_USAGE(g) +: 2];
         assign len_flat[2*g +: 2] = ctrl_r[`DBGEV_CTRL_LEN(g) +: 2];
         assign bp_en[g] = ctrl_r[`DBGEV_CTRL_LOCAL_EN(g)] |
            ctrl_r[`DBGEV_CTRL_GLOBAL_EN(g)];
      end
   endgenerate

   wire [NUM_BP-1:0] ins_hit;
   wire [NUM_BP-1:0] dat_hit;

   // Comparators for all breakpoints.
   dbgev_bp_match #(
      .NUM_BP(NUM_BP)
   ) u_match (
      .i_bp_addr(addr_flat),
      .i_usage(usage_flat),
      .i_len(len_flat),
      .i_ins_addr(i_ins_addr),
      .i_dat_dword(i_dat_dword),
      .i_dat_be(i_dat_be),
      .i_dat_wr(i_dat_wr),
      .o_ins_hit(ins_hit),
      .o_dat_hit(dat_hit)
   );

   // ---------------------------------------------------------------
   // Event detection
   // ---------------------------------------------------------------

   // Fault side: checked before the instruction runs.
   wire ins_any_en = i_ins_start && !i_resume_flag && |(ins_hit & bp_en);
   wire gd_fault = i_ins_start && i_dreg_access && ctrl_r[`DBGEV_CTRL_GD];
   wire fault = ins_any_en || gd_fault;

   // Data hits seen at this transfer.
   wire dat_any_en = i_dat_valid && |(dat_hit & bp_en);

   // Trap side: taken when the instruction retires.
   wire step_ev = i_ins_done && i_step_trap_flag;
   wire task_ev = i_ins_done && i_task_switch && i_tss_trap_bit;
   wire dat_ev = i_ins_done && (pend_en_r || dat_any_en);
   wire trap = step_ev || task_ev || dat_ev;

   // Data hits gathered during the current instruction.
   always @(posedge i_clk) begin
      if (i_reset) begin
         pend_hit_r <= {NUM_BP{1'b0}};
         pend_en_r <= 1'b0;
      end else if (i_ce) begin
         if (i_ins_done) begin
            pend_hit_r <= {NUM_BP{1'b0}};
            pend_en_r <= 1'b0;
         end else if (dat_any_en) begin
            pend_hit_r <= pend_hit_r | (dat_hit & {NUM_BP{i_dat_valid}});
            pend_en_r <= 1'b1;
         end
      end
   end

   // Status bits to set; all events of one boundary land together.
   reg [31:0] st_set;
   always @* begin
      st_set = `DBGEV_RST_WORD;
      if (ins_any_en) begin
         st_set[NUM_BP-1:0] = ins_hit;
      end
      if (dat_ev) begin
         st_set[NUM_BP-1:0] = st_set[NUM_BP-1:0] | pend_hit_r |
            (dat_any_en ? dat_hit : {NUM_BP{1'b0}});
      end
      st_set[`DBGEV_ST_GUARDED] = gd_fault;
      st_set[`DBGEV_ST_STEP] = step_ev;
      st_set[`DBGEV_ST_TASK] = task_ev;
   end

   // Write-one-to-clear from software, by byte strobes.
   wire [31:0] st_clr = stat_we ? (w_data_r & strb_bits(w_strb_r)) : `DBGEV_RST_WORD;

   // ---------------------------------------------------------------
   // Status, mask and interrupt
   // ---------------------------------------------------------------
   dbgev_irq u_irq (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_set(st_set),
      .i_clr(st_clr),
      .i_mask_we(mask_we),
      .i_mask_wdata(merge(mask, w_data_r, w_strb_r)),
      .o_status(status),
      .o_mask(mask),
      .o_irq(o_irq)
   );

   // ---------------------------------------------------------------
   // Control register and exception request
   // ---------------------------------------------------------------

   // Control; a guarded fault clears protection over a software write.
   always @(posedge i_clk) begin
      if (i_reset) begin
         ctrl_r <= `DBGEV_RST_WORD;
      end else if (i_ce) begin
         if (ctrl_we) begin
            ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r) & `DBGEV_CTRL_WMASK;
         end
         if (gd_fault) begin
            ctrl_r[`DBGEV_CTRL_GD] <= 1'b0;
         end
      end
   end

   assign o_global_detect_protect = ctrl_r[`DBGEV_CTRL_GD];

   // One-cycle request; a trap and a fault in the same cycle give one request, marked as a trap.
   always @(posedge i_clk) begin
      if (i_reset) begin
         o_dbg_exc <= 1'b0;
         o_exc_fault <= 1'b0;
      end else if (i_ce) begin
         o_dbg_exc <= fault || trap;
         o_exc_fault <= fault && !trap;
      end
   end

endmodule // dbgev_top
`default_nettype wire

// ---- bench/dsel_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ---------
// Port checker for the debug event block
// ---------
module dsel_props #(
   parameter NUM_BP = 4
) (
   // Clock and control.
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_ce,
   // Register bus handshakes.
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic o_bvalid,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic o_rvalid,
   // Core events.
   input wire logic i_ins_start,
   input wire logic i_resume_flag,
   input wire logic i_dreg_access,
   input wire logic i_ins_done,
   input wire logic i_step_trap_flag,
   input wire logic i_task_switch,
   input wire logic i_tss_trap_bit,
   // Exception request.
   input wire logic o_dbg_exc,
   input wire logic o_exc_fault,
   input wire logic o_global_detect_protect
);
   // All checks run on the core clock and rest during reset.
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);

   a_write_resp_seq: assert property (i_ce && i_awvalid && o_awready && i_wvalid && o_wready
      |=> !o_awready && !o_wready ##1 o_bvalid) else $error("write response out of order");
   a_read_resp_next: assert property (i_ce && i_arvalid && o_arready |=> o_rvalid)
      else $error("read response late");
   a_read_blocks_addr: assert property (o_rvalid |-> !o_arready) else $error("read address open during response");
   a_write_blocks_addr: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write channels open during response");
   a_idle_no_exc: assert property (i_ce && !i_ins_start && !i_ins_done |=> !o_dbg_exc)
      else $error("exception without boundary");
   a_resume_no_exc: assert property (i_ce && i_ins_start && i_resume_flag && !i_dreg_access && !i_ins_done
      |=> !o_dbg_exc) else $error("exception despite resume");
   a_guard_fault_clear: assert property (i_ce && i_ins_start && i_dreg_access && o_global_detect_protect
      && !i_ins_done |=> o_dbg_exc && o_exc_fault && !o_global_detect_protect) else $error("guarded access missed");
   a_step_trap_next: assert property (i_ce && i_ins_done && i_step_trap_flag |=> o_dbg_exc && !o_exc_fault)
      else $error("single step trap missed");
   a_task_trap_next: assert property (i_ce && i_ins_done && i_task_switch && i_tss_trap_bit
      |=> o_dbg_exc && !o_exc_fault) else $error("task switch trap missed");
endmodule // dsel_props

bind dbgev_top dsel_props #(.NUM_BP(NUM_BP)) dsel_props_inst (.*);
`default_nettype wire

// ---- bench/debug_status_event_logic_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dbgev_regs.vh"
module debug_status_event_logic_tb_top;
   // ---------
   // Signals
   // ---------
   logic i_clk, i_reset, i_ce, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_ins_start, i_resume_flag;
   logic i_dreg_access, i_dat_valid, i_dat_wr, i_ins_done, i_step_trap_flag, i_task_switch, i_tss_trap_bit;
   logic [4:0] i_awaddr, i_araddr;
   logic [31:0] i_wdata, i_ins_addr;
   logic [3:0] i_wstrb, i_dat_be;
   logic [29:0] i_dat_dword;
   wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_dbg_exc, o_exc_fault, o_global_detect_protect, o_irq;
   wire [1:0] o_bresp, o_rresp;
   wire [31:0] o_rdata;
   int miscompares = 0;
   int checked = 0;
   integer seed = 94304;

   // Design with the clock enable held high.
   dbgev_top #(.NUM_BP(4)) dbgev_top_inst (.*);

   // The 25 MHz core clock.
   always #20 i_clk = ~i_clk;

   // ---------
   // Checking and bus tasks
   // ---------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // One clock with a bound on how long any handshake may take.
   task automatic wt(inout int n);
      @(posedge i_clk);
      n++;
      if (n > 40) begin
         miscompares++;
         print_verdict();
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      int n;
      logic aw, w;
      n = 0;
      aw = 1'h0;
      w = 1'h0;
      i_awaddr <= a;
      i_wdata <= d;
      i_wstrb <= 4'hf;
      i_awvalid <= 1'h1;
      i_wvalid <= 1'h1;
      while (!(aw && w)) begin
         wt(n);
         aw = aw | o_awready;
         w = w | o_wready;
         i_awvalid <= !aw;
         i_wvalid <= !w;
      end
      // Response ready rises only once both address and data have been taken.
      i_bready <= 1'h1;
      while (o_bvalid !== 1'h1) wt(n);
      chk("bresp", o_bresp, er);
      i_bready <= 1'h0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
      int n;
      n = 0;
      i_araddr <= a;
      i_arvalid <= 1'h1;
      // Data ready is raised after the first edge and dropped once data is seen.
      do begin
         wt(n);
         if (o_arready) i_arvalid <= 1'h0;
         i_rready <= !o_rvalid;
      end while (o_rvalid !== 1'h1);
      d = o_rdata;
      chk("rresp", o_rresp, er);
   endtask

   task automatic st(input logic [31:0] e);
      logic [31:0] d;
      rd(`DBGEV_OFS_STATUS, d);
      chk("status", d, e);
   endtask

   // Lets the prepared event be sampled, then checks the exception request.
   task automatic fire(input logic ef, input logic ff);
      @(posedge i_clk);
      {i_ins_start, i_dat_valid, i_ins_done, i_resume_flag, i_dreg_access} <= '0;
      {i_step_trap_flag, i_task_switch, i_tss_trap_bit} <= '0;
      @(posedge i_clk);
      chk("exc", o_dbg_exc, ef);
      if (ef) chk("fault", o_exc_fault, ff);
   endtask

   // Expected breakpoint match for one access.
   function automatic logic hit(input logic [31:0] a, input logic [1:0] ln, input logic [1:0] us,
                                input logic [31:0] x, input logic [3:0] be, input logic w, input logic ex);
      logic [3:0] rg;
      rg = (ln == 2'h0) ? 4'h1 << a[1:0] : (ln == 2'h1) ? 4'h3 << {a[1], 1'h0} : 4'hf;
      return a[31:2] == x[31:2] && (rg & be) != 4'h0 && (ex ? us == 2'h0 : (us == 2'h3 || (us == 2'h1 && w)));
   endfunction

   // ---------
   // Main sequence
   // ---------
   initial begin
      logic [31:0] d, a, x;
      logic [3:0] be;
      logic [1:0] ln, us;
      logic ex, w, m;
      int bi;
      i_clk = 1'h0;
      i_ce = 1'h1;
      i_reset = 1'h1;
      {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_ins_start, i_resume_flag, i_dreg_access} = '0;
      {i_dat_valid, i_dat_wr, i_ins_done, i_step_trap_flag, i_task_switch, i_tss_trap_bit} = '0;
      {i_awaddr, i_araddr, i_wdata, i_ins_addr, i_wstrb, i_dat_be, i_dat_dword} = '0;
      repeat (10) @(posedge i_clk);
      i_reset <= 1'h0;
      @(posedge i_clk);
      // Reset values, the unmapped word, and address register storage.
      for (int r = 0; r < 8; r++) begin
         rd(5'(r * 4), d, r == 7 ? 2'h2 : 2'h0);
         chk("reset", d, 32'h0);
      end
      wr(5'h1c, 32'h1, 2'h2);
      a = $random(seed);
      wr(`DBGEV_OFS_BP_ADDR3, a);
      rd(`DBGEV_OFS_BP_ADDR3, d);
      chk("bp_addr", d, a);
      $display("Registers test done");
      // An enabled and a disabled breakpoint on one address, then resume.
      a = $random(seed);
      wr(`DBGEV_OFS_BP_ADDR0, a);
      wr(`DBGEV_OFS_BP_ADDR1, a);
      wr(`DBGEV_OFS_CTRL, 32'h1);
      i_ins_start <= 1'h1;
      i_ins_addr <= a;
      fire(1'h1, 1'h1);
      st(32'h3);
      wr(`DBGEV_OFS_STATUS, 32'hffffffff);
      i_ins_start <= 1'h1;
      i_resume_flag <= 1'h1;
      fire(1'h0, 1'h0);
      st(32'h0);
      $display("Breakpoint and resume test done");
      // Guarded access, then step and task switch together, with interrupts.
      wr(`DBGEV_OFS_CTRL, 32'h2000);
      chk("protect", o_global_detect_protect, 1'h1);
      i_ins_start <= 1'h1;
      i_ins_addr <= ~a;
      i_dreg_access <= 1'h1;
      fire(1'h1, 1'h1);
      chk("protect", o_global_detect_protect, 1'h0);
      i_ins_done <= 1'h1;
      i_step_trap_flag <= 1'h1;
      i_task_switch <= 1'h1;
      i_tss_trap_bit <= 1'h1;
      fire(1'h1, 1'h0);
      st(32'he000);
      chk("irq", o_irq, 1'h0);
      wr(`DBGEV_OFS_MASK, 32'h4000);
      chk("irq", o_irq, 1'h1);
      wr(`DBGEV_OFS_STATUS, 32'h4000);
      st(32'ha000);
      chk("irq", o_irq, 1'h0);
      wr(`DBGEV_OFS_STATUS, 32'hffffffff);
      $display("Event and interrupt test done");
      // Random breakpoint setups against nearby accesses.
      for (int k = 0; k < 24; k++) begin
         bi = {$random(seed)} % 4;
         a = $random(seed);
         ln = 2'({$random(seed)} % 3);
         if (ln == 2'h2) ln = 2'h3;
         us = 2'($random(seed));
         ex = 1'($random(seed));
         w = 1'($random(seed));
         x = {a[31:2] ^ 30'($random(seed) & 1), 2'($random(seed))};
         be = ex ? 4'h1 << x[1:0] : 4'($random(seed)) | 4'h1;
         m = hit(a, ln, us, x, be, w, ex);
         wr(5'(bi * 4), a);
         wr(`DBGEV_OFS_CTRL, (32'h1 << (2 * bi + 1)) | (us << (16 + 4 * bi)) | (ln << (18 + 4 * bi)));
         i_ins_start <= ex;
         i_ins_addr <= x;
         i_dat_valid <= !ex;
         i_dat_dword <= x[31:2];
         i_dat_be <= be;
         i_dat_wr <= w;
         fire(ex & m, 1'h1);
         if (!ex) begin
            i_ins_done <= 1'h1;
            fire(m, 1'h0);
         end
         st(32'(m) << bi);
         wr(`DBGEV_OFS_STATUS, 32'hffffffff);
      end
      $display("Random breakpoint test done");
      print_verdict();
   end
endmodule // debug_status_event_logic_tb_top
`default_nettype wire
